// *** rtl/rcs_pkg.sv ***
/*
 * Shared constants for the reset configuration strap capture block:
 * strap layout, field positions, reset values, sequencing counts, states.
 * Assumes a single core clock domain and an active high async reset.
 */
package rcs_pkg;

    // =====================================================================
    // strap layout
    localparam int STRAP_W = 16;
    localparam int PLAT_RATIO_LSB = 0;
    localparam int PLAT_RATIO_W = 4;
    localparam int CORE_RATIO_LSB = 4;
    localparam int CORE_RATIO_W = 3;
    localparam int GEN_CFG_LSB = 7;
    localparam int GEN_CFG_W = 9;

    // ratio straps carry no on-chip pull-up; all others do
    localparam logic [STRAP_W-1:0] PULLUP_MASK = 16'hff80;

    // value held before any capture: every bit in its default (high) state
    localparam logic [STRAP_W-1:0] CFG_RESET = 16'hffff;
    localparam logic [STRAP_W-1:0] PIN_OUT_RESET = 16'h0000;

    // =====================================================================
    // ratio encodings
    localparam logic [PLAT_RATIO_W-1:0] PLAT_RATIO_ILLEGAL = 4'h0;
    localparam logic [CORE_RATIO_W-1:0] CORE_RATIO_ILLEGAL = 3'h0;
    // communications-processor ratio to the platform clock, not selectable
    localparam logic [3:0] COMM_RATIO_FIXED = 4'h2;

    // =====================================================================
    // sequencing
    // core clock cycles the pull-ups and receivers stay on after release
    localparam int PULLUP_HOLD_CYC = 8;
    localparam int HOLD_CNT_W = 4;
    localparam logic [HOLD_CNT_W-1:0] HOLD_LAST = 4'(PULLUP_HOLD_CYC - 1);

    typedef enum logic [2:0] {
        ST_IN_RESET = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } rcs_state_type;

endpackage

// *** rtl/rcs_ratio_decode.sv ***
/*
 * Decodes the captured ratio fields into the multiplier controls for the
 * platform and core clock generators and drives the fixed ratio control
 * for the communications-processor clock generator.
 * Assumes the captured fields only change while the config is recaptured.
 */
`timescale 1ns/1ps

module rcs_ratio_decode (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // captured fields
    input wire logic [rcs_pkg::PLAT_RATIO_W-1:0] platRatioCode,
    input wire logic [rcs_pkg::CORE_RATIO_W-1:0] coreRatioCode,
    // multiplier controls
    output logic [rcs_pkg::PLAT_RATIO_W-1:0] platMult,
    output logic [rcs_pkg::CORE_RATIO_W-1:0] coreMult,
    output logic [3:0] commMult,
    output logic ratioValid
);
    import rcs_pkg::*;

    logic [PLAT_RATIO_W-1:0] platMult_q, platMult_d;
    logic [CORE_RATIO_W-1:0] coreMult_q, coreMult_d;
    logic ratioValid_q, ratioValid_d;

    // =====================================================================
    // decode
    always_comb begin
        platMult_d = platRatioCode;
        coreMult_d = coreRatioCode;
        // an all-zero code leaves the clock generator without a ratio
        ratioValid_d = (platRatioCode != PLAT_RATIO_ILLEGAL) &&
                       (coreRatioCode != CORE_RATIO_ILLEGAL);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            platMult_q <= CFG_RESET[PLAT_RATIO_LSB +: PLAT_RATIO_W];
            coreMult_q <= CFG_RESET[CORE_RATIO_LSB +: CORE_RATIO_W];
            ratioValid_q <= 1'b0;
        end else if (clkEn) begin
            platMult_q <= platMult_d;
            coreMult_q <= coreMult_d;
            ratioValid_q <= ratioValid_d;
        end
    end

    assign platMult = platMult_q;
    assign coreMult = coreMult_q;
    assign ratioValid = ratioValid_q;
    assign commMult = COMM_RATIO_FIXED;

endmodule // rcs_ratio_decode

// *** rtl/rcs_strap_capture.sv ***
/*
 * Power-on configuration strap capture: shared output pins act as inputs
 * with gated pull-ups while hard reset is held, are latched on release,
 * then return to output duty; captured ratio fields feed the clock setup.
 * Assumes hard_reset_n and the strap pin levels are synchronous to core_clk.
 * Limitation: straps are taken once, at the first edge that sees the pin
 * high; a strap that settles later is missed, so the board holds it steady.
 */
// Summary of operation
// - While hard reset is held low every strap pin is an input so the board level is seen.
// - The level on every strap pin is stored in the config register as hard reset releases.
// - After capture the input receivers are switched off and the pins resume output duty.
// - Pull-ups are on only in hard reset and a few cycles after, and drop with the receivers.
// - A pulled-up strap left open reads high, which selects that bit's default setting.
// - Platform and core ratio straps get no pull-up, so the board must drive them.
// - The platform clock multiple of the reference clock comes from the captured field.
// - The core clock multiple of the platform clock comes from the captured field.
// - The communications-processor clock ratio is fixed and nothing can change it.
`timescale 1ns/1ps

module rcs_strap_capture (
    // clock, reset, enable
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clkEn,
    // hard reset pin, active low
    input wire logic hard_reset_n,
    // strap pins, two-way
    input wire logic [rcs_pkg::STRAP_W-1:0] strapIn,
    output logic [rcs_pkg::STRAP_W-1:0] strapOut,
    output logic [rcs_pkg::STRAP_W-1:0] strapOe_n,
    // pad controls
    output logic [rcs_pkg::STRAP_W-1:0] pullUpEn,
    output logic [rcs_pkg::STRAP_W-1:0] rxEn,
    // normal function data for the pins
    input wire logic [rcs_pkg::STRAP_W-1:0] funcOut,
    // captured configuration
    output logic [rcs_pkg::STRAP_W-1:0] cfgBits,
    output logic [rcs_pkg::GEN_CFG_W-1:0] genCfg,
    output logic cfgCaptured,
    // clock generator controls
    output logic [rcs_pkg::PLAT_RATIO_W-1:0] platMult,
    output logic [rcs_pkg::CORE_RATIO_W-1:0] coreMult,
    output logic [3:0] commMult,
    output logic ratioValid
);
    import rcs_pkg::*;

    // =====================================================================
    // state
    rcs_state_type state_q, state_d;
    logic [HOLD_CNT_W-1:0] holdCnt_q, holdCnt_d;
    logic [STRAP_W-1:0] cfg_q, cfg_d;
    logic captured_q, captured_d;
    // first enabled edge in reset that sees the pin released
    logic capStrobe;
    // pad cells follow the next state so pads and state move together
    logic padRun;
    wire logic [STRAP_W-1:0] oeNBits;
    wire logic [STRAP_W-1:0] rxBits;
    wire logic [STRAP_W-1:0] pullUpBits;
    wire logic [STRAP_W-1:0] pinOutBits;

    // =====================================================================
    // sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IN_RESET: begin
                if (hard_reset_n) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!hard_reset_n) begin
                    state_d = ST_IN_RESET;
                end else if (holdCnt_q == HOLD_LAST) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!hard_reset_n) begin
                    state_d = ST_IN_RESET;
                end
            end
            default: begin
                state_d = ST_IN_RESET;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_q <= ST_IN_RESET;
        end else if (clkEn) begin
            state_q <= state_d;
        end
    end

    // =====================================================================
    // hold timer
    // counts the edges after release while pull-ups and receivers stay on
    always_comb begin
        holdCnt_d = holdCnt_q;
        if (state_q != ST_HOLD) begin
            holdCnt_d = '0;
        end else if (hard_reset_n && (holdCnt_q != HOLD_LAST)) begin
            holdCnt_d = holdCnt_q + 4'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            holdCnt_q <= '0;
        end else if (clkEn) begin
            holdCnt_q <= holdCnt_d;
        end
    end

    // =====================================================================
    // configuration capture
    // straps are looked at on this one edge only, never while pins drive
    assign capStrobe = (state_q == ST_IN_RESET) && hard_reset_n;

    always_comb begin
        cfg_d = cfg_q;
        captured_d = captured_q;
        if (capStrobe) begin
            cfg_d = strapIn;
            captured_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg_q <= CFG_RESET;
            captured_q <= 1'b0;
        end else if (clkEn) begin
            cfg_q <= cfg_d;
            captured_q <= captured_d;
        end
    end

    // =====================================================================
    // pad control, one cell per strap pin
    // registered so the pads never see decode glitches from the state
    assign padRun = (state_d == ST_RUN);

    for (genvar b = 0; b < STRAP_W; b++) begin : gPad
        logic oeN_q, oeN_d;
        logic rx_q, rx_d;
        logic pullUp_q, pullUp_d;
        logic pinOut_q, pinOut_d;

        always_comb begin
            oeN_d = 1'b1;
            rx_d = 1'b1;
            pinOut_d = PIN_OUT_RESET[b];
            pullUp_d = PULLUP_MASK[b];
            if (padRun) begin
                oeN_d = 1'b0;
                rx_d = 1'b0;
                pullUp_d = 1'b0;
                pinOut_d = funcOut[b];
            end
        end

        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                oeN_q <= 1'b1;
                rx_q <= 1'b1;
                pullUp_q <= PULLUP_MASK[b];
                pinOut_q <= PIN_OUT_RESET[b];
            end else if (clkEn) begin
                oeN_q <= oeN_d;
                rx_q <= rx_d;
                pullUp_q <= pullUp_d;
                pinOut_q <= pinOut_d;
            end
        end

        assign oeNBits[b] = oeN_q;
        assign rxBits[b] = rx_q;
        assign pullUpBits[b] = pullUp_q;
        assign pinOutBits[b] = pinOut_q;
    end

    assign strapOe_n = oeNBits;
    assign rxEn = rxBits;
    assign pullUpEn = pullUpBits;
    assign strapOut = pinOutBits;

    // =====================================================================
    // captured configuration
    assign cfgBits = cfg_q;
    assign genCfg = cfg_q[GEN_CFG_LSB +: GEN_CFG_W];
    assign cfgCaptured = captured_q;

    // =====================================================================
    // clock ratio controls
    // ratio codes settle one edge after capture, well inside the hold time
    rcs_ratio_decode uRatio (
        .core_clk(core_clk),
        .rst(rst),
        .clkEn(clkEn),
        .platRatioCode(cfg_q[PLAT_RATIO_LSB +: PLAT_RATIO_W]),
        .coreRatioCode(cfg_q[CORE_RATIO_LSB +: CORE_RATIO_W]),
        .platMult(platMult),
        .coreMult(coreMult),
        .commMult(commMult),
        .ratioValid(ratioValid)
    );

endmodule // rcs_strap_capture

// *** tb/rcs_board_model.sv ***
/* board side: strap resistors and pin levels seen by the device.
   assumes pull-downs win over the weak on-chip pull-ups. */
`timescale 1ns/1ps
module rcs_board_model import rcs_pkg::*; (
    // board fit
    input logic [STRAP_W-1:0] pullDn,
    input logic [STRAP_W-1:0] ratioDrv,
    // device pads
    input logic [STRAP_W-1:0] strapOut,
    input logic [STRAP_W-1:0] strapOe_n,
    input logic [STRAP_W-1:0] pullUpEn,
    input logic [STRAP_W-1:0] rxEn,
    output logic [STRAP_W-1:0] strapIn
);
    logic [STRAP_W-1:0] pin;
    // open strap high, ratio driven; unpulled floats toggle
    assign pin = (~strapOe_n & strapOut) | (strapOe_n & ((PULLUP_MASK & ~pullDn &
        (pullUpEn | ~strapOut)) | (~PULLUP_MASK & ratioDrv)));
    // disabled receiver gives garbage, never the pin level
    assign strapIn = (rxEn & pin) | (~rxEn & ~pin);
endmodule // rcs_board_model

// *** tb/rcs_strap_props.sv ***
/* checker for the strap capture block.
   assumes it is bound to rcs_strap_capture by tb. */
`timescale 1ns/1ps
module rcs_strap_props import rcs_pkg::*; (
    // clock and reset
    input logic core_clk,
    input logic rst,
    input logic clkEn,
    input logic hard_reset_n,
    // pins
    input logic [STRAP_W-1:0] strapIn,
    input logic [STRAP_W-1:0] strapOut,
    input logic [STRAP_W-1:0] strapOe_n,
    input logic [STRAP_W-1:0] pullUpEn,
    input logic [STRAP_W-1:0] rxEn,
    input logic [STRAP_W-1:0] funcOut,
    // results
    input logic [STRAP_W-1:0] cfgBits,
    input logic [GEN_CFG_W-1:0] genCfg,
    input logic cfgCaptured,
    input logic [PLAT_RATIO_W-1:0] platMult,
    input logic [CORE_RATIO_W-1:0] coreMult,
    input logic [3:0] commMult,
    input logic ratioValid
);
    // =====================================================================
    // helpers: tracks the in-reset state from the pins alone
    logic inRst_q;
    logic capEdge;
    logic [3:0] pc;
    logic [2:0] cc;
    assign capEdge = inRst_q && clkEn && hard_reset_n;
    assign pc = cfgBits[3:0];
    assign cc = cfgBits[6:4];
    always_ff @(posedge core_clk or posedge rst)
        if (rst) inRst_q <= 1'b1;
        else if (clkEn) inRst_q <= !hard_reset_n;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // =====================================================================
    // properties
    a_capture_edge: assert property (
        capEdge |=> cfgBits == $past(strapIn) && cfgCaptured) else $error("capture wrong");
    a_cfg_held: assert property (
        !capEdge |=> $stable(cfgBits)) else $error("config changed");
    a_hold_input: assert property (capEdge ##1 (clkEn && hard_reset_n)[*7]
        |=> pullUpEn == PULLUP_MASK && rxEn == '1) else $error("pads left early");
    a_run_release: assert property (capEdge ##1 (clkEn && hard_reset_n)[*8]
        |=> rxEn == '0 && pullUpEn == '0 && strapOe_n == '0) else $error("pads not freed");
    a_pull_gated: assert property (
        pullUpEn == (rxEn[0] ? PULLUP_MASK : '0) && rxEn == strapOe_n) else $error("pad mix");
    a_ratio_track: assert property (clkEn |=> platMult == $past(pc)
        && coreMult == $past(cc) && ratioValid == ($past(pc) != 0 && $past(cc) != 0))
        else $error("ratio wrong");
    a_comm_fixed: assert property (commMult == COMM_RATIO_FIXED) else $error("comm ratio");
    a_func_drive: assert property (
        clkEn && hard_reset_n && rxEn == '0 |=> strapOut == $past(funcOut)) else $error("out");
    a_gen_field: assert property (genCfg == cfgBits[15:7]) else $error("general field");
    a_reset_input: assert property (clkEn && !hard_reset_n
        |=> rxEn == '1 && strapOe_n == '1) else $error("pads not inputs");
endmodule // rcs_strap_props

// *** tb/tb.sv ***
/* top bench: strap capture across several board fits.
   assumes rcs_pkg, board model and checker compiled first. */
`timescale 1ns/1ps
module tb;
    import rcs_pkg::*;
    logic core_clk = 0, rst = 1, clkEn = 1, hard_reset_n = 0, cfgCaptured, ratioValid;
    logic [15:0] funcOut = 16'h0000, pullDn = 16'h0000, ratioDrv = 16'h0000, ex;
    logic [15:0] strapIn, strapOut, strapOe_n, pullUpEn, rxEn, cfgBits;
    logic [8:0] genCfg;
    logic [3:0] platMult, commMult;
    logic [2:0] coreMult;
    logic [15:0] pdTab [3] = '{16'h0000, 16'ha580, 16'hff80};
    logic [15:0] rdTab [3] = '{16'h0035, 16'h004a, 16'h0000};
    int n_fail = 0, comparisons = 0;
    always #10 core_clk = ~core_clk;
    rcs_strap_capture dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .hard_reset_n(hard_reset_n), .strapIn(strapIn), .strapOut(strapOut),
        .strapOe_n(strapOe_n), .pullUpEn(pullUpEn), .rxEn(rxEn), .funcOut(funcOut),
        .cfgBits(cfgBits), .genCfg(genCfg), .cfgCaptured(cfgCaptured), .platMult(platMult),
        .coreMult(coreMult), .commMult(commMult), .ratioValid(ratioValid));
    rcs_board_model board (.pullDn(pullDn), .ratioDrv(ratioDrv), .strapOut(strapOut),
        .strapOe_n(strapOe_n), .pullUpEn(pullUpEn), .rxEn(rxEn), .strapIn(strapIn));
    // =====================================================================
    // tasks
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task stop_test;
        $display("mismatches %0d comparisons %0d", n_fail, comparisons);
        if (n_fail == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // after release, pull-ups stay on for 7 more edges, then the 8th turns the pads to output
    task release_hold;
        tick(7);
        chk("pullUpEn hold", PULLUP_MASK, pullUpEn);
        tick(1);
        chk("strapOe_n run", 16'h0000, strapOe_n);
        chk("pullUpEn run", 16'h0000, pullUpEn);
        chk("rxEn run", 16'h0000, rxEn);
    endtask
    // =====================================================================
    // sequence
    initial begin
        #200000;
        n_fail++;
        stop_test;
    end
    initial begin
        tick(3);
        rst = 0;
        chk("cfgBits reset", CFG_RESET, cfgBits);
        chk("cfgCaptured reset", 16'h0000, cfgCaptured);
        chk("strapOe_n reset", 16'hffff, strapOe_n);
        chk("pullUpEn reset", PULLUP_MASK, pullUpEn);
        for (int i = 0; i < 3; i++) begin
            hard_reset_n = 0;
            pullDn = pdTab[i];
            ratioDrv = rdTab[i];
            ex = (PULLUP_MASK & ~pullDn) | (~PULLUP_MASK & ratioDrv);
            tick(2);
            chk("rxEn reset", 16'hffff, rxEn);
            hard_reset_n = 1;
            tick(1);
            chk("cfgBits", ex, cfgBits);
            chk("cfgCaptured", 16'h0001, cfgCaptured);
            chk("genCfg", ex[15:7], genCfg);
            release_hold;
            chk("platMult", ex[3:0], platMult);
            chk("coreMult", ex[6:4], coreMult);
            chk("ratioValid", ex[3:0] != 0 && ex[6:4] != 0, ratioValid);
            chk("commMult", COMM_RATIO_FIXED, commMult);
            funcOut = 16'h5a3c ^ ex;
            tick(1);
            chk("strapOut", 16'h5a3c ^ ex, strapOut);
            pullDn = ~pullDn;
            ratioDrv = ~ratioDrv;
            tick(2);
            chk("cfgBits kept", ex, cfgBits);
        end
        // abort mid-hold, re-release, then freeze the count
        hard_reset_n = 0;
        tick(2);
        hard_reset_n = 1;
        tick(3);
        hard_reset_n = 0;
        tick(1);
        pullDn = 16'ha580;
        ratioDrv = 16'h004a;
        hard_reset_n = 1;
        tick(1);
        chk("cfgBits recapture", (PULLUP_MASK & ~pullDn) | (~PULLUP_MASK & ratioDrv), cfgBits);
        clkEn = 0;
        tick(5);
        chk("rxEn frozen", 16'hffff, rxEn);
        clkEn = 1;
        release_hold;
        stop_test;
    end
endmodule // tb
bind rcs_strap_capture rcs_strap_props u_props (.core_clk(core_clk), .rst(rst),
    .clkEn(clkEn), .hard_reset_n(hard_reset_n), .strapIn(strapIn), .strapOut(strapOut),
    .strapOe_n(strapOe_n), .pullUpEn(pullUpEn), .rxEn(rxEn), .funcOut(funcOut),
    .cfgBits(cfgBits), .genCfg(genCfg), .cfgCaptured(cfgCaptured), .platMult(platMult),
    .coreMult(coreMult), .commMult(commMult), .ratioValid(ratioValid));
